// ===== core/irq_pkg.sv
// constants and register map of the grouped interrupt and tick timer
//
// How it works
// - tick source: 00 system clock, 01 system clock over four, 1x sub clock
// - unused bits of source select and tick control read as zero
// - top bit of tick control runs the tick counter
// - tick period is two to the power eight plus code prescaler cycles
// - a group flag sets whenever any source flag in that group becomes set
// - vector only with global enable set and stack not full, plus group and source enable for a group or tick enable for the tick
// - servicing a group clears that group flag and the global enable
// - servicing leaves source flags alone; software clears them by writes
// - group one holds conversion done and limit compare, each with an enable
// - limit flag sets on an enabled upper or lower bound hit
// - group one also holds capture overflow and capture match, each enabled
// - group two holds pwm period match and three duty matches, each enabled
// - group six holds the two wire flag with its own enable
// - timer period and a match flags, each enabled, in groups three to six
// - tick flag sets on overflow; servicing clears it and the global enable
// - return from interrupt sets the global enable again; plain return does not
// - any flag rising gives a wake pulse, enables ignored
package irq_pkg;
  localparam int DATA_W          = 8;
  localparam int ADDR_W          = 8;
  localparam int GROUPS          = 6;
  localparam int TIMERS          = 4;
  localparam int CNT_W           = 15;
  localparam int PERIOD_EXP_BASE = 8;
  localparam int SRC_W           = 8;
  localparam int EVT_W           = 3;

  // register offsets
  localparam logic [7:0] OFS_PRESCALER_CLOCK_SELECT = 8'h00;
  localparam logic [7:0] OFS_TIME_BASE_CONTROL      = 8'h01;
  localparam logic [7:0] OFS_GLOBAL_CTRL            = 8'h02;
  localparam logic [7:0] OFS_GROUP_ENABLE           = 8'h03;
  localparam logic [7:0] OFS_GROUP_FLAG             = 8'h04;
  localparam logic [7:0] OFS_SOURCE_FLAG            = 8'h05;
  localparam logic [7:0] OFS_SOURCE_ENABLE          = 8'h06;
  localparam logic [7:0] OFS_TIMER_FLAG             = 8'h07;
  localparam logic [7:0] OFS_TIMER_ENABLE           = 8'h08;
  localparam logic [7:0] OFS_TWO_WIRE_CTRL          = 8'h09;
  localparam logic [7:0] OFS_UPPER_BOUND            = 8'h0A;
  localparam logic [7:0] OFS_LOWER_BOUND            = 8'h0B;
  localparam logic [7:0] OFS_IRQ_STATUS             = 8'h0C;
  localparam logic [7:0] OFS_IRQ_CLEAR              = 8'h0D;
  localparam logic [7:0] OFS_IRQ_ENABLE             = 8'h0E;

  // field positions
  localparam int TICK_RUN_BIT   = 7;
  localparam int SRC_SEL_HI_BIT = 1;
  localparam int GLOBAL_EN_BIT  = 0;
  localparam int TICK_EN_BIT    = 1;
  localparam int TICK_FLAG_BIT  = 0;
  localparam int TW_FLAG_BIT    = 0;
  localparam int TW_EN_BIT      = 1;
  localparam int UPPER_EN_BIT   = 2;
  localparam int LOWER_EN_BIT   = 3;
  localparam int EVT_TICK       = 0;
  localparam int EVT_SERVICE    = 1;
  localparam int EVT_WAKE       = 2;
  // source flag layout: conv done, conv limit, cap ovf, cap match, pwm period, duty 0..2
  localparam int G1_LO = 0;
  localparam int G1_HI = 3;
  localparam int G2_LO = 4;
  localparam int G2_HI = 7;
  localparam int FIRST_TIMER_GROUP = 3;

  localparam logic [1:0] SEL_DIV4  = 2'h1;
  localparam logic [1:0] DIV4_LAST = 2'h3;
  localparam logic [2:0] VEC_TICK  = 3'h7;
  localparam logic [2:0] VEC_NONE  = 3'h0;
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ZERO = 15'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 15'h0001;
  localparam logic [CNT_W-1:0] CNT_ONES = 15'h7FFF;
endpackage

// ===== core/grouped_irq_and_tick_timer.sv
// grouped interrupt requests and periodic tick timer with register port
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/100ps
module grouped_irq_and_tick_timer (
  // clock, reset, enable
  input  wire logic                         clk_sys,
  input  wire logic                         reset,
  input  wire logic                         clk_en,
  // register port
  input  wire logic [irq_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [irq_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                         reg_write,
  input  wire logic                         reg_read,
  output logic      [irq_pkg::DATA_W-1:0]   reg_rdata,
  // sub clock pin
  input  wire logic                         sub_clk,
  // peripheral events, one-cycle pulses
  input  wire logic                         conv_done_evt,
  input  wire logic [irq_pkg::DATA_W-1:0]   conv_result,
  input  wire logic                         capture_overflow_evt,
  input  wire logic                         capture_match_evt,
  input  wire logic                         pwm_period_evt,
  input  wire logic [2:0]                   pwm_duty_evt,
  input  wire logic                         two_wire_evt,
  input  wire logic [irq_pkg::TIMERS-1:0]   timer_period_evt,
  input  wire logic [irq_pkg::TIMERS-1:0]   timer_a_evt,
  // core sequencer
  input  wire logic                         stack_full,
  input  wire logic                         irq_ack,
  input  wire logic                         return_from_interrupt,
  output logic                              irq_req,
  output logic      [2:0]                   irq_vector,
  output logic                              wake,
  output logic                              irq_line
);
  localparam int G = irq_pkg::GROUPS;

  logic [1:0]                  tick_source_select;
  logic                        tick_run;
  logic [2:0]                  tick_period_code;
  logic                        global_irq_enable;
  logic                        tick_enable;
  logic [G:1]                  group_enable;
  logic [G:1]                  group_request_flag;
  logic                        tick_request_flag;
  logic [irq_pkg::SRC_W-1:0]   src_flag;
  logic [irq_pkg::SRC_W-1:0]   src_enable;
  logic [irq_pkg::SRC_W-1:0]   timer_flag;
  logic [irq_pkg::SRC_W-1:0]   timer_enable;
  logic                        two_wire_flag;
  logic                        two_wire_enable;
  logic                        upper_bound_trigger_enable;
  logic                        lower_bound_trigger_enable;
  logic [irq_pkg::DATA_W-1:0]  upper_bound;
  logic [irq_pkg::DATA_W-1:0]  lower_bound;
  logic [irq_pkg::EVT_W-1:0]   irq_status;
  logic [irq_pkg::EVT_W-1:0]   irq_mask;
  logic [1:0]                  div4_cnt;
  logic [irq_pkg::CNT_W-1:0]   tick_cnt;
  logic                        sub_meta;
  logic                        sub_sync;
  logic                        sub_prev;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic wr(input logic [irq_pkg::ADDR_W-1:0] ofs);
    wr = reg_write && (reg_addr == ofs);
  endfunction

  function automatic logic [irq_pkg::CNT_W-1:0] period_last(input logic [2:0] code);
    period_last = ~(irq_pkg::CNT_ONES << (irq_pkg::PERIOD_EXP_BASE + int'(code)));
  endfunction

  // lowest active group wins, tick last
  function automatic logic [2:0] pick(input logic [G:1] act, input logic tick_act);
    pick = tick_act ? irq_pkg::VEC_TICK : irq_pkg::VEC_NONE;
    for (int g = G; g >= 1; g--) begin
      if (act[g]) begin
        pick = 3'(g);
      end
    end
  endfunction

  // ----------------------------------------
  // event decode
  // ----------------------------------------
  logic                       conv_limit_hit;
  logic [irq_pkg::SRC_W-1:0]  src_set;
  logic [irq_pkg::SRC_W-1:0]  timer_set;
  logic [G:1]                 group_rise;
  logic [G:1]                 group_act;
  logic                       psc_tick;
  logic                       tick_overflow;
  logic                       serviced;
  logic                       any_rise;

  assign conv_limit_hit = conv_done_evt &&
                          ((upper_bound_trigger_enable && conv_result > upper_bound) ||
                           (lower_bound_trigger_enable && conv_result < lower_bound));
  assign src_set   = {pwm_duty_evt, pwm_period_evt, capture_match_evt, capture_overflow_evt,
                      conv_limit_hit, conv_done_evt};
  assign timer_set = {timer_a_evt, timer_period_evt};
  assign serviced  = clk_en && irq_ack && irq_req;

  // a group rises when a flag goes from clear to set
  assign group_rise[1] = |(src_set[irq_pkg::G1_HI:irq_pkg::G1_LO] &
                           ~src_flag[irq_pkg::G1_HI:irq_pkg::G1_LO]);
  assign group_rise[2] = |(src_set[irq_pkg::G2_HI:irq_pkg::G2_LO] &
                           ~src_flag[irq_pkg::G2_HI:irq_pkg::G2_LO]);
  assign group_act[1]  = group_request_flag[1] && group_enable[1] &&
                         |(src_flag[irq_pkg::G1_HI:irq_pkg::G1_LO] &
                           src_enable[irq_pkg::G1_HI:irq_pkg::G1_LO]);
  assign group_act[2]  = group_request_flag[2] && group_enable[2] &&
                         |(src_flag[irq_pkg::G2_HI:irq_pkg::G2_LO] &
                           src_enable[irq_pkg::G2_HI:irq_pkg::G2_LO]);

  generate
    for (genvar t = 0; t < irq_pkg::TIMERS; t++) begin : g_timer
      localparam int GRP = irq_pkg::FIRST_TIMER_GROUP + t;
      logic rise_t;
      logic act_t;
      assign rise_t = (timer_set[t] && !timer_flag[t]) ||
                      (timer_set[t + irq_pkg::TIMERS] && !timer_flag[t + irq_pkg::TIMERS]);
      assign act_t  = (timer_flag[t] && timer_enable[t]) ||
                      (timer_flag[t + irq_pkg::TIMERS] && timer_enable[t + irq_pkg::TIMERS]);
      if (GRP == G) begin : g_last
        // two wire shares the last group
        assign group_rise[GRP] = rise_t || (two_wire_evt && !two_wire_flag);
        assign group_act[GRP]  = group_request_flag[GRP] && group_enable[GRP] &&
                                 (act_t || (two_wire_flag && two_wire_enable));
      end else begin : g_mid
        assign group_rise[GRP] = rise_t;
        assign group_act[GRP]  = group_request_flag[GRP] && group_enable[GRP] && act_t;
      end
    end
  endgenerate

  assign any_rise = (|group_rise) || (|(group_rise & ~group_request_flag)) ||
                    (tick_overflow && !tick_request_flag);

  // ----------------------------------------
  // tick source and counter
  // ----------------------------------------
  // sub clock is asynchronous; edges read only the second stage
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sub_meta <= 1'b0;
      sub_sync <= 1'b0;
      sub_prev <= 1'b0;
    end else if (clk_en) begin
      sub_meta <= sub_clk;
      sub_sync <= sub_meta;
      sub_prev <= sub_sync;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      div4_cnt <= 2'h0;
    end else if (clk_en) begin
      div4_cnt <= div4_cnt + 2'h1;
    end
  end

  always_comb begin
    if (tick_source_select[irq_pkg::SRC_SEL_HI_BIT]) begin
      psc_tick = sub_sync && !sub_prev;
    end else if (tick_source_select == irq_pkg::SEL_DIV4) begin
      psc_tick = (div4_cnt == irq_pkg::DIV4_LAST);
    end else begin
      psc_tick = 1'b1;
    end
  end

  assign tick_overflow = clk_en && tick_run && psc_tick &&
                         (tick_cnt == period_last(tick_period_code));

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tick_cnt <= irq_pkg::CNT_ZERO;
    end else if (clk_en) begin
      if (!tick_run) begin
        tick_cnt <= irq_pkg::CNT_ZERO;
      end else if (psc_tick) begin
        if (tick_cnt == period_last(tick_period_code)) begin
          tick_cnt <= irq_pkg::CNT_ZERO;
        end else begin
          tick_cnt <= tick_cnt + irq_pkg::CNT_ONE;
        end
      end
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tick_source_select <= 2'h0;
      tick_run           <= 1'b0;
      tick_period_code   <= 3'h0;
    end else if (clk_en) begin
      if (wr(irq_pkg::OFS_PRESCALER_CLOCK_SELECT)) begin
        tick_source_select <= reg_wdata[1:0];
      end
      if (wr(irq_pkg::OFS_TIME_BASE_CONTROL)) begin
        tick_run         <= reg_wdata[irq_pkg::TICK_RUN_BIT];
        tick_period_code <= reg_wdata[2:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      group_enable               <= '0;
      src_enable                 <= irq_pkg::RST_BYTE;
      timer_enable               <= irq_pkg::RST_BYTE;
      two_wire_enable            <= 1'b0;
      upper_bound_trigger_enable <= 1'b0;
      lower_bound_trigger_enable <= 1'b0;
      upper_bound                <= irq_pkg::RST_BYTE;
      lower_bound                <= irq_pkg::RST_BYTE;
      tick_enable                <= 1'b0;
      irq_mask                   <= '0;
    end else if (clk_en) begin
      if (wr(irq_pkg::OFS_GROUP_ENABLE))  group_enable <= reg_wdata[G:1];
      if (wr(irq_pkg::OFS_SOURCE_ENABLE)) src_enable   <= reg_wdata;
      if (wr(irq_pkg::OFS_TIMER_ENABLE))  timer_enable <= reg_wdata;
      if (wr(irq_pkg::OFS_UPPER_BOUND))   upper_bound  <= reg_wdata;
      if (wr(irq_pkg::OFS_LOWER_BOUND))   lower_bound  <= reg_wdata;
      if (wr(irq_pkg::OFS_IRQ_ENABLE))    irq_mask     <= reg_wdata[irq_pkg::EVT_W-1:0];
      if (wr(irq_pkg::OFS_GLOBAL_CTRL))   tick_enable  <= reg_wdata[irq_pkg::TICK_EN_BIT];
      if (wr(irq_pkg::OFS_TWO_WIRE_CTRL)) begin
        two_wire_enable            <= reg_wdata[irq_pkg::TW_EN_BIT];
        upper_bound_trigger_enable <= reg_wdata[irq_pkg::UPPER_EN_BIT];
        lower_bound_trigger_enable <= reg_wdata[irq_pkg::LOWER_EN_BIT];
      end
    end
  end

  // service beats a software write in the same cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      global_irq_enable <= 1'b0;
    end else if (clk_en) begin
      if (serviced) begin
        global_irq_enable <= 1'b0;
      end else if (return_from_interrupt) begin
        global_irq_enable <= 1'b1;
      end else if (wr(irq_pkg::OFS_GLOBAL_CTRL)) begin
        global_irq_enable <= reg_wdata[irq_pkg::GLOBAL_EN_BIT];
      end
    end
  end

  // ----------------------------------------
  // flags: written with new value, hardware set wins
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      src_flag      <= irq_pkg::RST_BYTE;
      timer_flag    <= irq_pkg::RST_BYTE;
      two_wire_flag <= 1'b0;
    end else if (clk_en) begin
      // only writes clear these
      src_flag   <= (wr(irq_pkg::OFS_SOURCE_FLAG) ? reg_wdata : src_flag) | src_set;
      timer_flag <= (wr(irq_pkg::OFS_TIMER_FLAG) ? reg_wdata : timer_flag) | timer_set;
      two_wire_flag <= (wr(irq_pkg::OFS_TWO_WIRE_CTRL) ? reg_wdata[irq_pkg::TW_FLAG_BIT]
                                                         : two_wire_flag) | two_wire_evt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      group_request_flag <= '0;
      tick_request_flag  <= 1'b0;
    end else if (clk_en) begin
      group_request_flag <= ((wr(irq_pkg::OFS_GROUP_FLAG) ? reg_wdata[G:1] : group_request_flag)
                             & ~(serviced ? G'((1 << irq_vector) >> 1) : G'(0)))
                            | group_rise;
      tick_request_flag  <= ((wr(irq_pkg::OFS_GROUP_FLAG) ? reg_wdata[irq_pkg::TICK_FLAG_BIT]
                                                           : tick_request_flag)
                             && !(serviced && irq_vector == irq_pkg::VEC_TICK))
                            || tick_overflow;
    end
  end

  // ----------------------------------------
  // request to the core
  // ----------------------------------------
  // request drops the cycle after the ack so one service never vectors twice
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_req    <= 1'b0;
      irq_vector <= irq_pkg::VEC_NONE;
    end else if (clk_en) begin
      irq_req    <= !serviced && global_irq_enable && !stack_full &&
                    ((|group_act) || (tick_request_flag && tick_enable));
      irq_vector <= pick(group_act, tick_request_flag && tick_enable);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wake <= 1'b0;
    end else if (clk_en) begin
      wake <= any_rise || (|(src_set & ~src_flag)) || (|(timer_set & ~timer_flag)) ||
              (two_wire_evt && !two_wire_flag);
    end
  end

  // ----------------------------------------
  // block interrupt line
  // ----------------------------------------
  logic [irq_pkg::EVT_W-1:0] evt_set;
  assign evt_set = {wake, serviced, tick_overflow};

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_status <= '0;
      irq_line   <= 1'b0;
    end else if (clk_en) begin
      irq_status <= (irq_status & ~(wr(irq_pkg::OFS_IRQ_CLEAR) ?
                                    reg_wdata[irq_pkg::EVT_W-1:0] : 3'h0)) | evt_set;
      irq_line   <= |(irq_status & irq_mask);
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata <= irq_pkg::RST_BYTE;
    end else if (clk_en) begin
      reg_rdata <= irq_pkg::RST_BYTE;
      if (reg_read) begin
        if (reg_addr == irq_pkg::OFS_PRESCALER_CLOCK_SELECT) begin
          reg_rdata <= {6'h00, tick_source_select};
        end else if (reg_addr == irq_pkg::OFS_TIME_BASE_CONTROL) begin
          reg_rdata <= {tick_run, 4'h0, tick_period_code};
        end else if (reg_addr == irq_pkg::OFS_GLOBAL_CTRL) begin
          reg_rdata <= {6'h00, tick_enable, global_irq_enable};
        end else if (reg_addr == irq_pkg::OFS_GROUP_ENABLE) begin
          reg_rdata <= {1'b0, group_enable, 1'b0};
        end else if (reg_addr == irq_pkg::OFS_GROUP_FLAG) begin
          reg_rdata <= {1'b0, group_request_flag, tick_request_flag};
        end else if (reg_addr == irq_pkg::OFS_SOURCE_FLAG) begin
          reg_rdata <= src_flag;
        end else if (reg_addr == irq_pkg::OFS_SOURCE_ENABLE) begin
          reg_rdata <= src_enable;
        end else if (reg_addr == irq_pkg::OFS_TIMER_FLAG) begin
          reg_rdata <= timer_flag;
        end else if (reg_addr == irq_pkg::OFS_TIMER_ENABLE) begin
          reg_rdata <= timer_enable;
        end else if (reg_addr == irq_pkg::OFS_TWO_WIRE_CTRL) begin
          reg_rdata <= {4'h0, lower_bound_trigger_enable, upper_bound_trigger_enable,
                        two_wire_enable, two_wire_flag};
        end else if (reg_addr == irq_pkg::OFS_UPPER_BOUND) begin
          reg_rdata <= upper_bound;
        end else if (reg_addr == irq_pkg::OFS_LOWER_BOUND) begin
          reg_rdata <= lower_bound;
        end else if (reg_addr == irq_pkg::OFS_IRQ_STATUS) begin
          reg_rdata <= {5'h00, irq_status};
        end else if (reg_addr == irq_pkg::OFS_IRQ_ENABLE) begin
          reg_rdata <= {5'h00, irq_mask};
        end
      end
    end
  end

endmodule

// ===== verif/core_seq_model.sv
// behavioural core sequencer: acknowledges requests, returns after a gap
`timescale 1ns/100ps
module core_seq_model #(parameter int RET_GAP = 24) (
  // clock
  input wire logic       clk_sys,
  input wire logic       reset,
  // request side
  input wire logic [3:0] ack_wait,
  input wire logic       irq_req,
  output logic           irq_ack,
  output logic           return_from_interrupt
);
  // ----------------
  // service loop
  // ----------------
  int wait_cnt;
  int ret_cnt;
  // one service at a time
  always_ff @(posedge clk_sys) begin
    irq_ack <= 1'b0;
    return_from_interrupt <= 1'b0;
    if (reset) begin
      wait_cnt <= 0;
      ret_cnt <= 0;
    end else if (ret_cnt != 0) begin
      ret_cnt <= ret_cnt - 1;
      return_from_interrupt <= (ret_cnt == 1);
    end else if (irq_req && !irq_ack) begin
      wait_cnt <= wait_cnt + 1;
      if (wait_cnt >= int'(ack_wait)) begin
        irq_ack <= 1'b1;
        ret_cnt <= RET_GAP;
        wait_cnt <= 0;
      end
    end else begin
      wait_cnt <= 0;
    end
  end
endmodule

// ===== verif/irq_props.sv
// assertion checker on the tick timer and grouped request ports
`timescale 1ns/100ps
module irq_props (
  // clock
  input wire logic       clk_sys,
  input wire logic       reset,
  input wire logic       clk_en,
  // registers
  input wire logic [7:0] reg_addr,
  input wire logic       reg_read,
  input wire logic       reg_write,
  input wire logic [7:0] reg_rdata,
  // core
  input wire logic       stack_full,
  input wire logic       irq_ack,
  input wire logic       return_from_interrupt,
  input wire logic       irq_req,
  input wire logic [2:0] irq_vector
);
  // ----------------
  // properties
  // ----------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  sequence s_taken; clk_en && irq_ack && irq_req; endsequence
  sequence s_calm; clk_en && !return_from_interrupt && !reg_write; endsequence
  property p_ack_drop; s_taken |=> !irq_req; endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("kept after ack");
  property p_held_off; s_taken ##1 s_calm [*3] |=> !irq_req; endproperty
  a_held_off: assert property (p_held_off) else $error("early request");
  property p_stack; clk_en && stack_full |=> !irq_req; endproperty
  a_stack: assert property (p_stack) else $error("full stack request");
  property p_vector; irq_req |-> irq_vector != irq_pkg::VEC_NONE; endproperty
  a_vector: assert property (p_vector) else $error("no vector");
  // only a write, a full stack or a service drops a request
  property p_hold; clk_en && irq_req && !irq_ack && !stack_full && !reg_write
    && !$past(reg_write) |=> irq_req; endproperty
  a_hold: assert property (p_hold) else $error("request dropped");
  property p_sel_gap; clk_en && reg_read && reg_addr == irq_pkg::OFS_PRESCALER_CLOCK_SELECT
    |=> reg_rdata[7:2] == 6'h00; endproperty
  a_sel_gap: assert property (p_sel_gap) else $error("select spare bits");
  property p_ctl_gap; clk_en && reg_read && reg_addr == irq_pkg::OFS_TIME_BASE_CONTROL
    |=> reg_rdata[6:3] == 4'h0; endproperty
  a_ctl_gap: assert property (p_ctl_gap) else $error("control spare bits");
  property p_idle_rd; clk_en && !reg_read |=> reg_rdata == 8'h00; endproperty
  a_idle_rd: assert property (p_idle_rd) else $error("stray read data");
  property p_frozen; !clk_en |=> $stable(irq_req) && $stable(irq_vector); endproperty
  a_frozen: assert property (p_frozen) else $error("moved while frozen");
endmodule
bind grouped_irq_and_tick_timer irq_props props (.clk_sys(clk_sys), .reset(reset),
  .clk_en(clk_en), .reg_addr(reg_addr), .reg_read(reg_read), .reg_write(reg_write),
  .reg_rdata(reg_rdata), .stack_full(stack_full), .irq_ack(irq_ack),
  .return_from_interrupt(return_from_interrupt), .irq_req(irq_req), .irq_vector(irq_vector));

// ===== verif/tb_top.sv
// bench: registers, tick timer, grouped events, masking, stack, priority, limits
`timescale 1ns/100ps
module tb_top;
  logic clk_sys = 1'b0, reset = 1'b1, clk_en = 1'b1, stack_full = 1'b0;
  logic reg_write = 1'b0, reg_read = 1'b0, irq_ack, return_from_interrupt;
  logic irq_req, wake, irq_line;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, conv_result = 8'h00, reg_rdata, v;
  logic [15:0] evt = 16'h0000;
  logic [3:0] ack_wait = 4'h2;
  logic [2:0] irq_vector;
  logic [7:0] sel[3] = '{8'h00, 8'h01, 8'h02}, ctl[3] = '{8'h80, 8'h81, 8'h80};
  logic [7:0] lr[6] = '{8'h90, 8'h08, 8'h40, 8'h90, 8'h08, 8'h80};
  logic [7:0] lc[6] = '{8'h0C, 8'h0C, 8'h0C, 8'h08, 8'h04, 8'h0C};
  logic [7:0] le[6] = '{8'h03, 8'h03, 8'h01, 8'h01, 8'h01, 8'h01};
  int lo[3] = '{252, 2044, 2200};
  int fail_count = 0, total_checks = 0, cyc = 0, n, ge;
  // ----------------
  // harness
  // ----------------
  always #2.5 clk_sys = ~clk_sys;
  grouped_irq_and_tick_timer dut (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .sub_clk(1'b0), .conv_done_evt(evt[0]), .conv_result(conv_result),
    .capture_overflow_evt(evt[1]), .capture_match_evt(evt[2]), .pwm_period_evt(evt[3]),
    .pwm_duty_evt(evt[6:4]), .timer_period_evt(evt[10:7]), .timer_a_evt(evt[14:11]),
    .two_wire_evt(evt[15]), .stack_full(stack_full), .irq_ack(irq_ack),
    .return_from_interrupt(return_from_interrupt), .irq_req(irq_req),
    .irq_vector(irq_vector), .wake(wake), .irq_line(irq_line));
  core_seq_model core (.clk_sys(clk_sys), .reset(reset), .ack_wait(ack_wait),
    .irq_req(irq_req), .irq_ack(irq_ack), .return_from_interrupt(return_from_interrupt));
  // gap cycle after each strobe
  task automatic wr(input logic [7:0] a, d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic chk(input logic [7:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, exp);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    @(posedge clk_sys);
    chk(reg_rdata, exp);
  endtask
  task automatic fire(input logic [15:0] m);
    evt <= m;
    @(posedge clk_sys);
    evt <= 16'h0000;
    @(posedge clk_sys);
  endtask
  task automatic serve(input logic [7:0] ev, gf, g);
    v = 8'h00;
    for (n = 0; n < 300 && v === 8'h00; n++) begin
      @(posedge clk_sys);
      if (irq_ack === 1'b1) v = {5'h00, irq_vector};
    end
    chk(v, ev);
    rc(8'h04, gf);
    rc(8'h02, g);
    for (n = 0; n < 60 && return_from_interrupt !== 1'b1; n++) @(posedge clk_sys);
    @(posedge clk_sys);
    rc(8'h02, g | 8'h01);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end
  // ----------------
  // tests
  // ----------------
  initial begin
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    clk_en <= 1'b0;
    repeat (3) @(posedge clk_sys);
    clk_en <= 1'b1;
    rc(8'h00, 8'h00);
    rc(8'h01, 8'h00);
    wr(8'h00, 8'hFF);
    rc(8'h00, 8'h03);
    wr(8'h01, 8'hFF);
    rc(8'h01, 8'h87);
    rc(8'h3F, 8'h00);
    $display("register test done");
    wr(8'h0E, 8'h01);
    for (int i = 0; i < 3; i++) begin
      wr(8'h01, 8'h00);
      wr(8'h00, sel[i]);
      wr(8'h01, ctl[i]);
      for (n = 0; n < 2200 && irq_line !== 1'b1; n++) @(posedge clk_sys);
      chk({7'h00, n >= lo[i] && n <= lo[i] + 8}, 8'h01);
      wr(8'h0D, 8'hFF);
    end
    wr(8'h04, 8'h00);
    wr(8'h02, 8'h03);
    wr(8'h00, 8'h00);
    wr(8'h01, 8'h80);
    serve(8'h07, 8'h00, 8'h02);
    wr(8'h01, 8'h00);
    $display("tick test done");
    wr(8'h02, 8'h01);
    wr(8'h03, 8'h7E);
    wr(8'h06, 8'hFF);
    wr(8'h08, 8'hFF);
    wr(8'h09, 8'h02);
    wr(8'h0D, 8'hFF);
    wr(8'h0E, 8'h00);
    for (int k = 0; k < 16; k++) begin
      fire(16'h0001 << k);
      chk({7'h00, wake}, 8'h01);
      ge = k < 3 ? 1 : k < 7 ? 2 : k < 11 ? k - 4 : k < 15 ? k - 8 : 6;
      serve(8'(ge), 8'h00, 8'h00);
      rc(8'h05, k == 0 ? 8'h01 : k < 7 ? 8'h01 << (k + 1) : 8'h00);
      rc(8'h07, k > 6 && k < 15 ? 8'h01 << (k - 7) : 8'h00);
      rc(8'h09, k == 15 ? 8'h03 : 8'h02);
      wr(8'h05, 8'h00);
      wr(8'h07, 8'h00);
      wr(8'h09, 8'h02);
    end
    rc(8'h0C, 8'h06);
    chk({7'h00, irq_line}, 8'h00);
    wr(8'h0E, 8'h04);
    @(posedge clk_sys);
    chk({7'h00, irq_line}, 8'h01);
    wr(8'h0D, 8'hFF);
    @(posedge clk_sys);
    chk({7'h00, irq_line}, 8'h00);
    $display("event test done");
    wr(8'h06, 8'h00);
    fire(16'h0001);
    chk({7'h00, wake}, 8'h01);
    repeat (4) @(posedge clk_sys);
    chk({7'h00, irq_req}, 8'h00);
    wr(8'h05, 8'h00);
    wr(8'h04, 8'h00);
    wr(8'h06, 8'hFF);
    stack_full <= 1'b1;
    ack_wait <= 4'h6;
    fire(16'h0008);
    repeat (4) @(posedge clk_sys);
    chk({7'h00, irq_req}, 8'h00);
    stack_full <= 1'b0;
    serve(8'h02, 8'h00, 8'h00);
    wr(8'h05, 8'h00);
    ack_wait <= 4'h2;
    fire(16'h0009);
    serve(8'h01, 8'h04, 8'h00);
    serve(8'h02, 8'h00, 8'h00);
    $display("mask stack priority test done");
    wr(8'h02, 8'h00);
    wr(8'h0A, 8'h80);
    wr(8'h0B, 8'h10);
    for (int i = 0; i < 6; i++) begin
      wr(8'h09, lc[i]);
      conv_result <= lr[i];
      wr(8'h05, 8'h00);
      fire(16'h0001);
      rc(8'h05, le[i]);
    end
    $display("limit test done");
    give_verdict();
  end
endmodule
